/* tbd_cfg.svh */
`ifndef TBD_CFG_SVH
`define TBD_CFG_SVH
// ****************************************
// register offsets within the io window
// ****************************************
`define TBD_OFS_CNT0    8'h00
`define TBD_OFS_CNT1    8'h04
`define TBD_OFS_CNT2    8'h08
`define TBD_OFS_CTRL    8'h0C
`define TBD_OFS_SEL     8'h10
`define TBD_OFS_DIO     8'h14
`define TBD_OFS_EXT     8'h18
`define TBD_OFS_DORB    8'h1C
`define TBD_OFS_ID      8'h3C
// ****************************************
// field positions and reset values
// ****************************************
`define TBD_SEL_LSB     0
`define TBD_SEL_MSB     1
`define TBD_ID_SW_MSB   3
`define TBD_DO_RST      16'h0000
`define TBD_SEL_RST     2'h0
`define TBD_EXT_RST     16'h0000
// ****************************************
// configuration identity, values arbitrary
// ****************************************
`define TBD_CFG_VENDOR  16'h1A2B
`define TBD_CFG_DEVICE  16'h3C4D
`define TBD_CFG_SUBVEN  16'h5E6F
`define TBD_CFG_SUBDEV  16'h7081
// ****************************************
// configuration space dword offsets
// ****************************************
`define TBD_CFGO_ID     6'h00
`define TBD_CFGO_SUBID  6'h0B
`endif

/* tbd_pkg.sv */
package tbd_pkg;
    typedef logic [1:0]  tbd_chip_t;
    typedef logic [15:0] tbd_word_t;
    typedef enum logic [2:0] {
        TBD_R_CNT0,
        TBD_R_CNT1,
        TBD_R_CNT2,
        TBD_R_CTRL,
        TBD_R_NONE
    } tbd_cnt_reg_t;
endpackage

/* tbd_chip_if.sv */
`timescale 1ns/1ns
interface tbd_chip_if;
    logic [3:0] cs;
    logic [1:0] addr;
    logic       rd;
    logic       wr;
    logic [7:0] wdata;
    logic [7:0] rdata0;
    logic [7:0] rdata1;
    logic [7:0] rdata2;
    logic [7:0] rdata3;
    modport dec (output cs, addr, rd, wr, wdata, input rdata0, rdata1, rdata2, rdata3);
    modport chip (input cs, addr, rd, wr, wdata, output rdata0, rdata1, rdata2, rdata3);
endinterface

/* tbd_sync2.sv */
`timescale 1ns/1ns
module tbd_sync2 #(
    parameter int W = 16
) (
    input  wire logic         i_mclk,
    input  wire logic         i_rst_b,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
    } tbd_sync_st_t;
    tbd_sync_st_t st_q;
    tbd_sync_st_t st_d;
    always_comb begin
        st_d      = st_q;
        st_d.meta = i_async;
        st_d.sync = st_q.meta;
    end
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
    assign o_sync = st_q.sync;
endmodule // tbd_sync2

/* tbd_io_decoder.sv */
`timescale 1ns/1ns
// Behaviour
// RULE1 - write 0x10 updates active chip selection
// RULE2 - select bits: 00..11 pick chips one..four
// RULE3 - all chips count; only selected responds
// RULE4 - host selects chip before counter access
// RULE5 - offsets 0,4,8,0xC route to selected chip
// RULE6 - read 0x14 returns sixteen input lines
// RULE7 - write 0x14 drives sixteen output lines
// RULE8 - 0x18 reads extended status; write sets extended control and clears irq
// RULE9 - config space holds four identity values
// RULE10 - read 0x1C returns last output word
// RULE11 - read 0x3C returns switches, upper zero
// RULE12 - select ignores bits 7..2; reads meaningless
`include "tbd_cfg.svh"
module tbd_io_decoder (
    input  wire logic             i_mclk,
    input  wire logic             i_rst_b,
    input  wire logic [7:0]       i_io_addr,
    input  wire logic             i_io_rd,
    input  wire logic             i_io_wr,
    input  wire logic [15:0]      i_io_wdata,
    input  wire logic [5:0]       i_cfg_addr,
    input  wire logic             i_cfg_rd,
    input  wire tbd_pkg::tbd_word_t i_input_lines,
    input  wire logic [3:0]       i_board_number_switch,
    input  wire logic [15:0]      i_ext_status,
    input  wire logic [7:0]       i_chip_rdata0,
    input  wire logic [7:0]       i_chip_rdata1,
    input  wire logic [7:0]       i_chip_rdata2,
    input  wire logic [7:0]       i_chip_rdata3,
    output logic [3:0]            o_chip_cs,
    output logic [1:0]            o_chip_addr,
    output logic                  o_chip_rd,
    output logic                  o_chip_wr,
    output logic [7:0]            o_chip_wdata,
    output logic [15:0]           o_output_lines,
    output logic [15:0]           o_ext_ctrl,
    output logic                  o_irq_clear,
    output logic [15:0]           o_io_rdata,
    output logic                  o_io_rvalid,
    output logic [31:0]           o_cfg_rdata,
    output logic                  o_cfg_rvalid
);
    import tbd_pkg::*;

    // ****************************************
    // input synchronisers
    // ****************************************
    logic [15:0] di_sync;
    logic [3:0]  sw_sync;
    logic [15:0] es_sync;

    tbd_sync2 #(.W(16)) u_di_sync (
        .i_mclk  (i_mclk),
        .i_rst_b (i_rst_b),
        .i_async (i_input_lines),
        .o_sync  (di_sync)
    );
    tbd_sync2 #(.W(4)) u_sw_sync (
        .i_mclk  (i_mclk),
        .i_rst_b (i_rst_b),
        .i_async (i_board_number_switch),
        .o_sync  (sw_sync)
    );
    tbd_sync2 #(.W(16)) u_es_sync (
        .i_mclk  (i_mclk),
        .i_rst_b (i_rst_b),
        .i_async (i_ext_status),
        .o_sync  (es_sync)
    );

    // ****************************************
    // counter chip bus carrier
    // ****************************************
    tbd_chip_if u_chip ();
    assign u_chip.rdata0 = i_chip_rdata0;
    assign u_chip.rdata1 = i_chip_rdata1;
    assign u_chip.rdata2 = i_chip_rdata2;
    assign u_chip.rdata3 = i_chip_rdata3;

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        tbd_chip_t sel;
        tbd_word_t dout;
        tbd_word_t ext;
        logic      irq_clr;
        logic [3:0] cs;
        logic [1:0] caddr;
        logic      crd;
        logic      cwr;
        logic [7:0] cwdata;
        logic      chip_rd_pend;
        tbd_word_t rdata;
        logic      rvalid;
        logic [31:0] cfg_rdata;
        logic      cfg_rvalid;
    } tbd_dec_st_t;

    tbd_dec_st_t  st_q;
    tbd_dec_st_t  st_d;
    tbd_cnt_reg_t creg;
    logic [7:0]   chip_mux;

    // ****************************************
    // counter offset classification
    // ****************************************
    always_comb begin
        if (i_io_addr == `TBD_OFS_CNT0) begin
            creg = TBD_R_CNT0; // see RULE5
        end else if (i_io_addr == `TBD_OFS_CNT1) begin
            creg = TBD_R_CNT1;
        end else if (i_io_addr == `TBD_OFS_CNT2) begin
            creg = TBD_R_CNT2;
        end else if (i_io_addr == `TBD_OFS_CTRL) begin
            creg = TBD_R_CTRL;
        end else begin
            creg = TBD_R_NONE;
        end
    end

    // selected chip read data
    always_comb begin
        case (st_q.sel)
            2'h0:    chip_mux = u_chip.rdata0;
            2'h1:    chip_mux = u_chip.rdata1;
            2'h2:    chip_mux = u_chip.rdata2;
            default: chip_mux = u_chip.rdata3;
        endcase
    end

    // ****************************************
    // register address decode
    // ****************************************
    logic hit_sel;
    logic hit_dio;
    logic hit_ext;
    logic hit_dorb;
    logic hit_id;
    always_comb begin
        hit_sel  = 1'b0;
        hit_dio  = 1'b0;
        hit_ext  = 1'b0;
        hit_dorb = 1'b0;
        hit_id   = 1'b0;
        if (i_io_addr == `TBD_OFS_SEL) begin
            hit_sel = 1'b1;
        end else if (i_io_addr == `TBD_OFS_DIO) begin
            hit_dio = 1'b1;
        end else if (i_io_addr == `TBD_OFS_EXT) begin
            hit_ext = 1'b1;
        end else if (i_io_addr == `TBD_OFS_DORB) begin
            hit_dorb = 1'b1;
        end else if (i_io_addr == `TBD_OFS_ID) begin
            hit_id = 1'b1;
        end
    end

    // ****************************************
    // request qualification
    // ****************************************
    logic       chip_hit;
    logic       rd_go;
    logic       wr_sel;
    logic       wr_dio;
    logic       wr_ext;
    logic [3:0] chip_onehot;
    assign chip_hit = (creg != TBD_R_NONE);
    assign rd_go    = i_io_rd && !i_io_wr;
    assign wr_sel   = i_io_wr && hit_sel;
    assign wr_dio   = i_io_wr && hit_dio;
    assign wr_ext   = i_io_wr && hit_ext;

    // ****************************************
    // chip strobe for the active selection
    // ****************************************
    always_comb begin
        case (st_q.sel)
            2'h0:    chip_onehot = 4'h1; // see RULE2
            2'h1:    chip_onehot = 4'h2;
            2'h2:    chip_onehot = 4'h4;
            default: chip_onehot = 4'h8;
        endcase
    end

    // ****************************************
    // register read data
    // ****************************************
    tbd_word_t   reg_rdata;
    logic [31:0] cfg_word;
    // unmapped and write-only offsets read as zero
    always_comb begin
        if (hit_dio) begin
            reg_rdata = di_sync; // see RULE6
        end else if (hit_ext) begin
            reg_rdata = es_sync; // see RULE8
        end else if (hit_dorb) begin
            reg_rdata = st_q.dout; // see RULE10
        end else if (hit_id) begin
            reg_rdata = {12'h000, sw_sync}; // see RULE11
        end else begin
            reg_rdata = 16'h0000; // see RULE12
        end
    end

    // ****************************************
    // configuration identity
    // ****************************************
    always_comb begin
        if (i_cfg_addr == `TBD_CFGO_ID) begin
            cfg_word = {`TBD_CFG_DEVICE, `TBD_CFG_VENDOR}; // see RULE9
        end else if (i_cfg_addr == `TBD_CFGO_SUBID) begin
            cfg_word = {`TBD_CFG_SUBDEV, `TBD_CFG_SUBVEN}; // see RULE9
        end else begin
            cfg_word = 32'h0000_0000;
        end
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        st_d              = st_q;
        st_d.irq_clr      = 1'b0;
        st_d.cs           = 4'h0;
        st_d.crd          = 1'b0;
        st_d.cwr          = 1'b0;
        st_d.rvalid       = 1'b0;
        st_d.cfg_rvalid   = 1'b0;
        st_d.chip_rd_pend = 1'b0;

        // chip read answers one cycle after strobe
        if (st_q.chip_rd_pend) begin
            st_d.rdata  = {8'h00, chip_mux};
            st_d.rvalid = 1'b1;
        end

        // write wins over a read in the same cycle
        if (i_io_wr && chip_hit) begin
            st_d.cs     = chip_onehot; // see RULE3 see RULE5
            st_d.caddr  = creg[1:0];
            st_d.cwr    = 1'b1;
            st_d.cwdata = i_io_wdata[7:0];
        end else if (wr_sel) begin
            st_d.sel = i_io_wdata[`TBD_SEL_MSB:`TBD_SEL_LSB]; // see RULE1 see RULE2 see RULE12
        end else if (wr_dio) begin
            st_d.dout = i_io_wdata; // see RULE7
        end else if (wr_ext) begin
            st_d.ext     = i_io_wdata;
            st_d.irq_clr = 1'b1; // see RULE8
        end else if (rd_go && chip_hit) begin
            st_d.cs           = chip_onehot; // see RULE5
            st_d.caddr        = creg[1:0];
            st_d.crd          = 1'b1;
            st_d.chip_rd_pend = 1'b1;
        end else if (rd_go) begin
            st_d.rvalid = 1'b1;
            st_d.rdata  = reg_rdata;
        end

        if (i_cfg_rd) begin
            st_d.cfg_rvalid = 1'b1;
            st_d.cfg_rdata  = cfg_word;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_q      <= '0;
            st_q.sel  <= `TBD_SEL_RST;
            st_q.dout <= `TBD_DO_RST;
            st_q.ext  <= `TBD_EXT_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign u_chip.cs    = st_q.cs;
    assign u_chip.addr  = st_q.caddr;
    assign u_chip.rd    = st_q.crd;
    assign u_chip.wr    = st_q.cwr;
    assign u_chip.wdata = st_q.cwdata;

    // ****************************************
    // host side outputs
    // ****************************************
    assign o_chip_cs      = u_chip.cs;
    assign o_chip_addr    = u_chip.addr;
    assign o_chip_rd      = u_chip.rd;
    assign o_chip_wr      = u_chip.wr;
    assign o_chip_wdata   = u_chip.wdata;
    assign o_output_lines = st_q.dout;
    assign o_ext_ctrl     = st_q.ext;
    assign o_irq_clear    = st_q.irq_clr;
    assign o_io_rdata     = st_q.rdata;
    assign o_io_rvalid    = st_q.rvalid;
    assign o_cfg_rdata    = st_q.cfg_rdata;
    assign o_cfg_rvalid   = st_q.cfg_rvalid;
endmodule // tbd_io_decoder

/* tbd_chips_model.sv */
`timescale 1ns/1ns
// ****************
// counter chips
// ****************
module tbd_chips_model (
    input  wire logic       i_mclk,
    input  wire logic       i_rst_b,
    input  wire logic [3:0] i_cs,
    input  wire logic [1:0] i_addr,
    input  wire logic       i_wr,
    input  wire logic [7:0] i_wdata,
    output logic      [7:0] o_rdata [4]
);
    logic [7:0] mem_q [4][4];
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            mem_q <= '{default: 8'h00};
        end else begin
            for (int c = 0; c < 4; c++) begin
                if (i_cs[c] && i_wr) begin
                    mem_q[c][i_addr] <= i_wdata;
                end
            end
        end
    end
    always_comb begin
        for (int c = 0; c < 4; c++) begin
            o_rdata[c] = i_cs[c] ? mem_q[c][i_addr] : ~mem_q[c][i_addr];
        end
    end
endmodule // tbd_chips_model

/* tbd_io_decoder_checker.sv */
`timescale 1ns/1ns
// ****************
// port checks
// ****************
module tbd_io_decoder_checker (
    input wire logic        i_mclk,
    input wire logic        i_rst_b,
    input wire logic [7:0]  i_io_addr,
    input wire logic        i_io_rd,
    input wire logic        i_io_wr,
    input wire logic [15:0] i_io_wdata,
    input wire logic        i_cfg_rd,
    input wire logic [3:0]  o_chip_cs,
    input wire logic [1:0]  o_chip_addr,
    input wire logic        o_chip_rd,
    input wire logic        o_chip_wr,
    input wire logic [15:0] o_output_lines,
    input wire logic        o_irq_clear,
    input wire logic [15:0] o_io_rdata,
    input wire logic        o_io_rvalid,
    input wire logic        o_cfg_rvalid
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_b);
    logic       cnt, cw, cr, acc, xw, rd1;
    logic [1:0] ca;
    assign cnt = i_io_addr[7:4] == 4'h0 && i_io_addr[1:0] == 2'h0;
    assign cw = i_io_wr && cnt;
    assign rd1 = i_io_rd && !i_io_wr;
    assign cr = rd1 && cnt;
    assign acc = cw || cr;
    assign xw = i_io_wr && i_io_addr == 8'h18;
    assign ca = i_io_addr[3:2];
    logic [1:0] sel_q;
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sel_q <= 2'h0;
        end else if (i_io_wr && i_io_addr == 8'h10) begin
            sel_q <= i_io_wdata[1:0];
        end
    end
    chip_pick_a: assert property (acc |=> o_chip_cs == 4'h1 << $past(sel_q))
        else $error("wrong chip strobed");
    chip_write_a: assert property (cw |=> o_chip_wr && $onehot(o_chip_cs) && o_chip_addr == $past(ca))
        else $error("chip write not routed");
    chip_read_a: assert property (cr |=> o_chip_rd && $onehot(o_chip_cs) ##1 o_io_rvalid)
        else $error("chip read not routed");
    strobe_cause_a: assert property (o_chip_cs != 4'h0 |-> $past(acc))
        else $error("chip strobe without access");
    dout_write_a: assert property (i_io_wr && i_io_addr == 8'h14 |=> o_output_lines == $past(i_io_wdata))
        else $error("output lines not updated");
    irq_clear_a: assert property (o_irq_clear == $past(xw))
        else $error("clear strobe wrong");
    dout_rback_a: assert property (rd1 && i_io_addr == 8'h1C |=> o_io_rvalid && o_io_rdata == o_output_lines)
        else $error("readback wrong");
    id_upper_a: assert property (rd1 && i_io_addr == 8'h3C |=> o_io_rvalid && o_io_rdata[15:4] == 12'h000)
        else $error("id upper bits not zero");
    sel_read_a: assert property (rd1 && i_io_addr == 8'h10 |=> o_io_rvalid && o_io_rdata == 16'h0000)
        else $error("select read not zero");
    cfg_answer_a: assert property (i_cfg_rd |=> o_cfg_rvalid)
        else $error("config read unanswered");
    cover property (cr);
    cover property (xw);
    cover property (i_cfg_rd);
endmodule // tbd_io_decoder_checker
bind tbd_io_decoder tbd_io_decoder_checker chk (.*);

/* tbd_io_decoder_tb.sv */
`timescale 1ns/1ns
`include "tbd_cfg.svh"
// ****************
// bench
// ****************
module tbd_io_decoder_tb;
    import tbd_pkg::*;
    logic        i_mclk, i_rst_b, i_io_rd, i_io_wr, i_cfg_rd;
    logic        o_chip_rd, o_chip_wr, o_io_rvalid, o_cfg_rvalid, o_irq_clear;
    logic [7:0]  i_io_addr, o_chip_wdata, rdata [4];
    logic [15:0] i_io_wdata, i_ext_status, o_output_lines, o_ext_ctrl, o_io_rdata;
    logic [5:0]  i_cfg_addr;
    logic [3:0]  i_board_number_switch, o_chip_cs;
    logic [1:0]  o_chip_addr;
    logic [31:0] o_cfg_rdata;
    logic [7:0]  exp_mem [4][4];
    tbd_word_t   i_input_lines;
    int          errors, checked;
    tbd_io_decoder dut (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_io_addr(i_io_addr), .i_io_rd(i_io_rd),
        .i_io_wr(i_io_wr), .i_io_wdata(i_io_wdata), .i_cfg_addr(i_cfg_addr), .i_cfg_rd(i_cfg_rd),
        .i_input_lines(i_input_lines), .i_board_number_switch(i_board_number_switch),
        .i_ext_status(i_ext_status), .i_chip_rdata0(rdata[0]), .i_chip_rdata1(rdata[1]),
        .i_chip_rdata2(rdata[2]), .i_chip_rdata3(rdata[3]), .o_chip_cs(o_chip_cs), .o_chip_addr(o_chip_addr),
        .o_chip_rd(o_chip_rd), .o_chip_wr(o_chip_wr), .o_chip_wdata(o_chip_wdata),
        .o_output_lines(o_output_lines), .o_ext_ctrl(o_ext_ctrl), .o_irq_clear(o_irq_clear),
        .o_io_rdata(o_io_rdata), .o_io_rvalid(o_io_rvalid), .o_cfg_rdata(o_cfg_rdata),
        .o_cfg_rvalid(o_cfg_rvalid));
    tbd_chips_model chips (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_cs(o_chip_cs), .i_addr(o_chip_addr),
        .i_wr(o_chip_wr), .i_wdata(o_chip_wdata), .o_rdata(rdata));
    function automatic logic [31:0] exp_id(input logic [3:0] sw);
        return {28'h0000000, sw};
    endfunction
    function automatic logic [31:0] exp_cfg(input logic sub);
        return sub ? {`TBD_CFG_SUBDEV, `TBD_CFG_SUBVEN} : {`TBD_CFG_DEVICE, `TBD_CFG_VENDOR};
    endfunction
    task automatic wrap_up();
        if (errors == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic io_wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge i_mclk);
        i_io_addr <= a;
        i_io_wdata <= d;
        i_io_wr <= 1'b1;
        @(posedge i_mclk);
        i_io_wr <= 1'b0;
        repeat (2) @(negedge i_mclk);
    endtask
    task automatic rd_chk(input logic cfg, input logic [7:0] a, input logic [31:0] exp);
        int n;
        @(posedge i_mclk);
        i_io_addr <= a;
        i_cfg_addr <= a[5:0];
        i_io_rd <= !cfg;
        i_cfg_rd <= cfg;
        @(posedge i_mclk);
        i_io_rd <= 1'b0;
        i_cfg_rd <= 1'b0;
        @(negedge i_mclk);
        for (n = 0; n < 4 && o_io_rvalid !== 1'b1 && o_cfg_rvalid !== 1'b1; n++) @(negedge i_mclk);
        if (n == 4) begin
            errors++;
            wrap_up();
        end else begin
            check(cfg ? o_cfg_rdata : {16'h0000, o_io_rdata}, exp);
        end
    endtask
    initial begin
        i_mclk = 1'b0;
        forever #4 i_mclk = ~i_mclk;
    end
    initial begin
        logic [15:0] v;
        {i_rst_b, i_io_rd, i_io_wr, i_cfg_rd, i_io_addr, i_cfg_addr} = '0;
        {i_io_wdata, i_ext_status, i_input_lines, i_board_number_switch} = '0;
        errors = 0;
        checked = 0;
        v = 16'($urandom(32'hCB41));
        repeat (2) @(posedge i_mclk);
        i_rst_b <= 1'b1;
        @(negedge i_mclk);
        check({16'h0000, o_output_lines}, 32'h0);
        for (int c = 0; c < 4; c++) begin
            io_wr(8'h10, 16'($urandom) & 16'hFFFC | 16'(c));
            for (int r = 0; r < 4; r++) begin
                exp_mem[c][r] = 8'($urandom);
                io_wr(8'(r * 4), {8'h00, exp_mem[c][r]});
            end
        end
        for (int c = 3; c >= 0; c--) begin
            io_wr(8'h10, 16'(c));
            for (int r = 0; r < 4; r++) rd_chk(1'b0, 8'(r * 4), {24'h0, exp_mem[c][r]});
        end
        for (int k = 0; k < 4; k++) begin
            v = (k == 0) ? 16'hFFFF : 16'($urandom);
            @(posedge i_mclk);
            i_input_lines <= v;
            i_ext_status <= ~v;
            i_board_number_switch <= v[3:0];
            repeat (3) @(posedge i_mclk);
            rd_chk(1'b0, 8'h14, {16'h0000, v});
            rd_chk(1'b0, 8'h18, {16'h0000, ~v});
            rd_chk(1'b0, 8'h3C, exp_id(v[3:0]));
            io_wr(8'h14, v ^ 16'h5A5A);
            check({16'h0000, o_output_lines}, {16'h0000, v ^ 16'h5A5A});
            io_wr(8'h1C, v);
            io_wr(8'h18, v);
            check({16'h0000, o_ext_ctrl}, {16'h0000, v});
            rd_chk(1'b0, 8'h1C, {16'h0000, v ^ 16'h5A5A});
        end
        @(posedge i_mclk);
        i_rst_b <= 1'b0;
        repeat (2) @(posedge i_mclk);
        i_rst_b <= 1'b1;
        @(negedge i_mclk);
        check({o_ext_ctrl, o_output_lines}, 32'h0);
        io_wr(8'h04, 16'h00A5);
        rd_chk(1'b0, 8'h04, 32'h000000A5);
        rd_chk(1'b0, 8'h10, 32'h0);
        rd_chk(1'b0, 8'h20, 32'h0);
        rd_chk(1'b1, 8'h00, exp_cfg(1'b0));
        rd_chk(1'b1, 8'h0B, exp_cfg(1'b1));
        rd_chk(1'b1, 8'h01, 32'h0);
        wrap_up();
    end
endmodule // tbd_io_decoder_tb
